// ===== rtl/lrs_err_flag.sv
// One sticky per-byte receive error flag
`timescale 1ns/1ps
module lrs_err_flag (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rstn_in,
  // Control
  input  wire logic unit_power_enable_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  // Status
  output logic      flag_out
);
  typedef struct packed {
    logic flag;
  } lrs_flag_state_t;

  lrs_flag_state_t state_reg;
  lrs_flag_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (!unit_power_enable_in) begin
      state_next.flag = 1'b0;
    end else if (set_in) begin
      // Set beats a simultaneous clear so no error is lost
      state_next.flag = 1'b1;
    end else if (clear_in) begin
      state_next.flag = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag_out = state_reg.flag;
endmodule : lrs_err_flag

// ===== rtl/lrs_pkg.sv
// Constants and types for the receive-status-low word
package lrs_pkg;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned NUM_BYTES     = 12;
  localparam int unsigned CODE_W        = 3;
  localparam logic [ADDR_W-1:0] RX_STATUS_LOW_OFFSET = 8'h88;
  localparam int unsigned CODE_MSB      = 15;
  localparam int unsigned CODE_LSB      = 13;
  localparam int unsigned UNUSED_BIT    = 12;
  localparam int unsigned FLAGS_MSB     = 11;
  localparam int unsigned FLAGS_LSB     = 0;
  localparam logic [CODE_W-1:0] CODE_IDLE     = 3'h0;
  localparam logic [CODE_W-1:0] CODE_PARTIAL  = 3'h1;
  localparam logic [CODE_W-1:0] CODE_ABNORMAL = 3'h7;
  localparam logic [DATA_W-1:0] RDATA_RESET   = 16'h0000;
  localparam logic [NUM_BYTES-1:0] FLAGS_RESET = 12'h000;

  typedef enum logic [1:0] {
    LRS_ST_IDLE,
    LRS_ST_PARTIAL,
    LRS_ST_ABNORMAL
  } lrs_rx_state_t;
endpackage : lrs_pkg

// ===== rtl/lrs_rx_status_low.sv
// Receive-status-low word: buffer state code and sticky per-byte error flags
`timescale 1ns/1ps
// Functional notes
// - Read-only 16-bit status word at offset 0x88, whole 16-bit reads only.
// - Bits 15:13 hold the buffer state code; zero means idle.
// - Distinct code when data arrived but programmed length not yet reached.
// - Any other code flags abnormal operation; software must request an abort.
// - Bits 11:0 set when the receiver detects an error on that byte.
// - Flag bit n belongs to receive buffer byte n, 0 to 11.
// - Flags stay set until software writes one to the matching clear bit.
// - Clearing unit enable resets state code and all flags to zero.
module lrs_rx_status_low
(
  // Clock and reset
  input  wire logic                            clock_in,
  input  wire logic                            rstn_in,
  // Unit control
  input  wire logic                            unit_power_enable_in,
  input  wire logic                            rx_abort_request_in,
  input  wire logic [lrs_pkg::NUM_BYTES-1:0]   rx_byte_error_clear_in,
  // Receiver events
  input  wire logic                            rx_byte_stored_in,
  input  wire logic                            rx_length_reached_in,
  input  wire logic                            rx_fault_in,
  input  wire logic [lrs_pkg::NUM_BYTES-1:0]   rx_byte_error_detect_in,
  // Register port
  input  wire logic [lrs_pkg::ADDR_W-1:0]      reg_addr_in,
  input  wire logic                            reg_rd_in,
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_size16_in,
  output logic      [lrs_pkg::DATA_W-1:0]      reg_rdata_out,
  output logic                                 reg_rvalid_out,
  // Status
  output logic      [lrs_pkg::CODE_W-1:0]      rx_buffer_state_code_out,
  output logic      [lrs_pkg::NUM_BYTES-1:0]   rx_byte_error_flags_out
);
  import lrs_pkg::*;

  // Everything the word keeps itself; the sticky flags live in their own cells
  typedef struct packed {
    lrs_rx_state_t        rx_state;
    logic [CODE_W-1:0]    code;
    logic [DATA_W-1:0]    rdata;
    logic                 rvalid;
  } lrs_state_t;

  // State registers
  lrs_state_t             state_reg;
  lrs_state_t             state_next;
  lrs_rx_state_t          rx_state_next;
  // Status word assembly
  logic [NUM_BYTES-1:0]   flags;
  logic [CODE_W-1:0]      code_next;
  logic [DATA_W-1:0]      status_word;
  // Per-byte strobes
  logic [NUM_BYTES-1:0]   flag_set;
  logic [NUM_BYTES-1:0]   flag_clear;
  // Register decode
  logic                   addr_match;
  logic                   size_match;
  logic                   hit;
  logic                   rd_hit;
  // Receiver events qualified by the unit enable
  logic                   ev_abort;
  logic                   ev_fault;
  logic                   ev_short;
  logic                   ev_done;

  // Word layout seen by software:
  //   15:13  receive-buffer state code
  //   12     unused, always zero
  //   11:0   sticky error flag, bit n for receive buffer byte n

  // Kept as named vectors so the byte order is stated in one place
  always_comb begin
    flag_set   = rx_byte_error_detect_in;
    flag_clear = rx_byte_error_clear_in;
  end

  // One cell per byte; inside each cell a set beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTES; gi++) begin : g_flag
      lrs_err_flag u_flag (
        .clock_in             (clock_in),
        .rstn_in              (rstn_in),
        .unit_power_enable_in (unit_power_enable_in),
        .set_in               (flag_set[gi]),
        .clear_in             (flag_clear[gi]),
        .flag_out             (flags[gi])
      );
    end
  endgenerate

  // Code of the state being entered, so the code output comes from a register
  always_comb begin
    case (rx_state_next)
      LRS_ST_IDLE: begin
        code_next = CODE_IDLE;
      end
      LRS_ST_PARTIAL: begin
        code_next = CODE_PARTIAL;
      end
      LRS_ST_ABNORMAL: begin
        code_next = CODE_ABNORMAL;
      end
      default: begin
        // An undefined next state reports abnormal; an undefined current state goes to idle and reports idle
        code_next = CODE_ABNORMAL;
      end
    endcase
  end

  always_comb begin
    status_word                      = RDATA_RESET;
    status_word[CODE_MSB:CODE_LSB]   = state_reg.code;
    // Kept explicit so no later field can drift onto the unused bit
    status_word[UNUSED_BIT]          = 1'b0;
    status_word[FLAGS_MSB:FLAGS_LSB] = flags;
  end

  // Byte or word-pair accesses are not decoded and return zero
  always_comb begin
    // Offset within the unit's register space
    addr_match = (reg_addr_in == RX_STATUS_LOW_OFFSET);
    // Only a whole 16-bit access reaches the word
    size_match = reg_size16_in;
    hit        = addr_match && size_match;
    rd_hit     = reg_rd_in && hit;
  end

  // A disabled unit ignores every receiver event and any abort
  always_comb begin
    // Abort request from the receive control word
    ev_abort = unit_power_enable_in && rx_abort_request_in;
    // Receive process left its normal path
    ev_fault = unit_power_enable_in && rx_fault_in;
    // A byte stored before the programmed length
    ev_short = unit_power_enable_in && rx_byte_stored_in && !rx_length_reached_in;
    // Programmed length reached: the frame is complete
    ev_done  = unit_power_enable_in && rx_length_reached_in;
  end

  // Fault outranks a stored byte in idle; abort outranks everything later on
  always_comb begin
    rx_state_next = state_reg.rx_state;
    case (state_reg.rx_state)
      LRS_ST_IDLE: begin
        // An abort in idle has nothing to undo
        if (ev_fault) begin
          rx_state_next = LRS_ST_ABNORMAL;
        end else if (ev_short) begin
          rx_state_next = LRS_ST_PARTIAL;
        end else begin
          rx_state_next = LRS_ST_IDLE;
        end
      end
      LRS_ST_PARTIAL: begin
        // Only an abort recovers a short frame; length reached completes it
        if (ev_abort) begin
          rx_state_next = LRS_ST_IDLE;
        end else if (ev_fault) begin
          rx_state_next = LRS_ST_ABNORMAL;
        end else if (ev_done) begin
          rx_state_next = LRS_ST_IDLE;
        end else begin
          rx_state_next = LRS_ST_PARTIAL;
        end
      end
      LRS_ST_ABNORMAL: begin
        // The code holds so software can see where the process stalled
        if (ev_abort) begin
          rx_state_next = LRS_ST_IDLE;
        end else begin
          rx_state_next = LRS_ST_ABNORMAL;
        end
      end
      default: begin
        rx_state_next = LRS_ST_IDLE;
      end
    endcase
    // Enable low is a synchronous clear of the whole receive process
    if (!unit_power_enable_in) begin
      rx_state_next = LRS_ST_IDLE;
    end
  end

  // The one process that fills the next copy of the state
  always_comb begin
    state_next          = state_reg;
    state_next.rx_state = rx_state_next;
    state_next.code     = code_next;
    state_next.rvalid   = reg_rd_in;
    // A miss still answers, with zero, so a read never waits
    if (rd_hit) begin
      state_next.rdata = status_word;
    end else begin
      state_next.rdata = RDATA_RESET;
    end
    // reg_wr_in is deliberately ignored: the word has no writable state
  end

  // rdata and rvalid stand for one cycle after each read strobe
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg.rx_state <= LRS_ST_IDLE;
      state_reg.code     <= CODE_IDLE;
      state_reg.rdata    <= RDATA_RESET;
      state_reg.rvalid   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a register or a flag cell's register
  assign reg_rdata_out            = state_reg.rdata;
  assign reg_rvalid_out           = state_reg.rvalid;
  assign rx_buffer_state_code_out = state_reg.code;
  assign rx_byte_error_flags_out  = flags;
endmodule : lrs_rx_status_low

// ===== tb/lrs_checker.sv
// Port assertions for the receive-status-low word
`timescale 1ns/1ps
module lrs_checker (
  input wire logic clock_in, rstn_in, unit_power_enable_in, rx_abort_request_in, rx_fault_in,
  input wire logic rx_byte_stored_in, rx_length_reached_in, reg_rd_in, reg_size16_in, reg_rvalid_out,
  input wire logic [11:0] rx_byte_error_clear_in, rx_byte_error_detect_in, rx_byte_error_flags_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [2:0] rx_buffer_state_code_out
);
  wire en = unit_power_enable_in;
  wire ab = rx_abort_request_in;
  wire [2:0] c = rx_buffer_state_code_out;
  wire [11:0] f = rx_byte_error_flags_out;
  wire hit = reg_addr_in == 8'h88 && reg_size16_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  property p_rv; reg_rd_in |=> reg_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("rv");
  property p_word; reg_rd_in && hit |=> reg_rdata_out == {$past(c), 1'b0, $past(f)}; endproperty
  a_word: assert property (p_word) else $error("word");
  property p_miss; reg_rd_in && !hit |=> reg_rdata_out == 16'h0000; endproperty
  a_miss: assert property (p_miss) else $error("miss");
  property p_part; en && c == 3'h0 && rx_byte_stored_in && !rx_length_reached_in && !rx_fault_in
    |=> c == 3'h1; endproperty
  a_part: assert property (p_part) else $error("part");
  property p_bad; en && !ab && (rx_fault_in || c == 3'h7) |=> c == 3'h7; endproperty
  a_bad: assert property (p_bad) else $error("bad");
  property p_abort; en && ab && c != 3'h0 |=> c == 3'h0; endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_flag; en |=> f == ($past(f) & ~$past(rx_byte_error_clear_in) | $past(rx_byte_error_detect_in));
  endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_off; !en |=> c == 3'h0 && f == 12'h000; endproperty
  a_off: assert property (p_off) else $error("off");
endmodule : lrs_checker

bind lrs_rx_status_low lrs_checker u_chk (.*);

// ===== tb/tb_top.sv
// Random bench for the receive-status-low word
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, en, ab, st, ln, ft, rd, wr, sz, rv;
  logic [11:0] clr, det, fl;
  logic [7:0] ad;
  logic [15:0] rdat;
  logic [2:0] cd;
  int num_errors = 0, samples_checked = 0, cyc = 0, mc = 0, mf = 0, er, ev;
  always #25 clk = ~clk;
  lrs_rx_status_low uut (.clock_in(clk), .rstn_in(rst_n), .unit_power_enable_in(en), .rx_abort_request_in(ab),
    .rx_byte_error_clear_in(clr), .rx_byte_stored_in(st), .rx_length_reached_in(ln), .rx_fault_in(ft),
    .rx_byte_error_detect_in(det), .reg_addr_in(ad), .reg_rd_in(rd), .reg_wr_in(wr), .reg_size16_in(sz),
    .reg_rdata_out(rdat), .reg_rvalid_out(rv), .rx_buffer_state_code_out(cd), .rx_byte_error_flags_out(fl));
  task chk(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask : chk
  task conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Abort only outside idle: its effect there is left open
  task step(input int off);
    {st, ln, rd, wr, sz} = $urandom;
    ft = $urandom % 9 == 0;
    ab = mc != 0 && $urandom % 4 == 0;
    en = $urandom % 100 >= off;
    det = $urandom % 5 ? 12'h000 : 12'($urandom);
    clr = $urandom % 3 ? 12'h000 : 12'($urandom);
    ad = $urandom % 4 ? 8'h88 : 8'($urandom);
    @(posedge clk);
    ev = rd;
    er = rd && ad == 8'h88 && sz ? mc << 13 | mf : 0;
    mf = en ? mf & ~clr | det : 0;
    if (!en || mc != 0 && (ab || mc == 1 && ln && !ft)) mc = 0;
    else if (ft || mc == 7) mc = 7;
    else if (st && !ln) mc = 1;
    #5;
    chk(rv, ev);
    chk(rdat, er);
    chk(cd, mc);
    chk(fl, mf);
  endtask : step
  always @(posedge clk) begin
    if (++cyc == 3000) begin
      num_errors++;
      conclude;
    end
  end
  initial begin
    void'($urandom(32'h2FF2));
    {en, ab, st, ln, ft, rd, wr, sz, clr, det, ad} = '0;
    repeat (3) @(posedge clk);
    #5 rst_n = 1;
    repeat (700) step(0);
    $display("random traffic done");
    repeat (500) step(20);
    $display("enable toggling done");
    rst_n = 0;
    mc = 0;
    mf = 0;
    #20 chk({cd, 1'b0, fl}, 0);
    @(posedge clk);
    #5 rst_n = 1;
    repeat (300) step(5);
    $display("mid-run reset done");
    conclude;
  end
endmodule : tb_top
